//--- hdl/spc_stop_ctrl.sv
`timescale 1ns/10ps
// Behaviour
// - debug keepalive set at stop entry keeps debug logic clocked during stop
// - debug keepalive at entry keeps regulator in full regulation
// - deep stop request with debug keepalive set enters shallow stop instead
// - status memory commands while stopped get an error, no memory access
// - background command during stop wakes into background mode when enabled
// - in background mode every debug command is accepted
// - deep stop powers off all but ram and a kept rtc, and latches pin controls
// - deep stop exits on reset pin or external wake pin
// - external wake pin is active-low wake input during deep stop
// - rtc interrupt, when enabled, wakes from deep stop
// - deep stop wake acts as power-on reset, low trip lvd, reset vector
// - deep stop wake sets partial powerdown flag
// - flag and pin latches hold until acknowledge written as 1
// - on acknowledge pins follow current port or peripheral configuration
// - every stop mode halts peripheral clocks, even with debug kept alive
// - deep stop switches modules except a kept rtc and regulator off; shallow stop holds standby
// - rtc runs in stop only if prescale select was nonzero at entry
// - adc runs in shallow stop only with async clock and lvd enabled
// - comparator on bandgap runs in shallow stop only with lvd enabled
// - usb stays on in shallow stop only with module and transceiver enables
// - ref clock needs enable and stop enable; crystal also lvd if high range
// - stop without stop enable resets; else debug or lvd pick shallow stop
// - lvd enabled for stop keeps regulator active and forces shallow stop
module spc_stop_ctrl #(
    parameter int unsigned PIN_W = spc_pkg::PIN_W_DEF
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // cpu stop request and configuration
    input wire logic stop_exec_in,
    input wire logic stop_instruction_enable_in,
    input wire logic debug_keepalive_enable_in,
    input wire logic low_voltage_detect_enable_in,
    input wire logic low_voltage_stop_enable_in,
    input wire logic partial_powerdown_select_in,
    input wire logic partial_powerdown_acknowledge_in,
    // peripheral configuration seen at stop entry; rtc irq enable and interrupts are read live during stop
    input wire logic [spc_pkg::RTC_PS_W-1:0] rtc_prescale_select_in,
    input wire logic rtc_irq_enable_in,
    input wire logic rtc_irq_in,
    input wire logic adc_async_clock_enable_in,
    input wire logic comparator_bandgap_select_in,
    input wire logic usb_module_enable_in,
    input wire logic usb_transceiver_enable_in,
    input wire logic internal_ref_clock_enable_in,
    input wire logic internal_ref_stop_enable_in,
    input wire logic external_ref_clock_enable_in,
    input wire logic external_ref_stop_enable_in,
    input wire logic crystal_high_range_in,
    input wire logic other_irq_in,
    // pins from outside
    input wire logic reset_pin_n_in,
    input wire logic external_wake_pin_n_in,
    // debug host
    input wire logic dbg_background_cmd_in,
    input wire logic dbg_status_mem_cmd_in,
    input wire logic dbg_go_cmd_in,
    // pin control from ports and peripherals
    input wire logic [PIN_W-1:0] pin_ctrl_in,
    // mode and power outputs
    output logic [1:0] mode_out,
    output logic illegal_opcode_reset_out,
    output logic por_reset_out,
    output logic lvd_low_trip_out,
    output logic fetch_reset_vector_out,
    output logic partial_powerdown_flag_out,
    output logic [PIN_W-1:0] pin_ctrl_out,
    output logic periph_clk_en_out,
    output logic debug_clk_en_out,
    output logic regulator_full_out,
    output logic core_power_on_out,
    output logic rtc_run_out,
    output logic adc_run_out,
    output logic comparator_run_out,
    output logic usb_run_out,
    output logic internal_ref_run_out,
    output logic crystal_run_out,
    // debug answers
    output logic dbg_status_error_out,
    output logic dbg_full_cmds_out
);

    typedef struct packed {
        spc_pkg::spc_mode_t mode;
        logic dbg_keep;
        logic lvd_stop;
        logic rtc_keep;
        logic adc_keep;
        logic cmp_keep;
        logic usb_keep;
        logic irc_keep;
        logic crystal_oscillator_keep;
        logic ppd_flag;
        logic latched;
        logic [PIN_W-1:0] pins;
        logic ill_rst;
        logic por_rst;
        logic dbg_err;
        logic rst_s1;
        logic rst_s2;
        logic wake_s1;
        logic wake_s2;
    } spc_state_t;

    spc_state_t st_q;
    spc_state_t st_d;

    // ==========================================================
    // stop mode selection
    logic lvd_in_stop;
    logic stop_to_deep;
    logic deep_wake;
    logic shallow_wake;

    assign lvd_in_stop = low_voltage_detect_enable_in & low_voltage_stop_enable_in;
    // debug or lvd in stop override a deep request
    assign stop_to_deep = partial_powerdown_select_in & ~debug_keepalive_enable_in
        & ~lvd_in_stop;
    // only synchronised pin copies are looked at
    assign deep_wake = ~st_q.rst_s2 | ~st_q.wake_s2
        | (rtc_irq_enable_in & rtc_irq_in & st_q.rtc_keep);
    assign shallow_wake = ~st_q.rst_s2 | other_irq_in | rtc_irq_in;

    // ==========================================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.rst_s1 = reset_pin_n_in;
        st_d.rst_s2 = st_q.rst_s1;
        st_d.wake_s1 = external_wake_pin_n_in;
        st_d.wake_s2 = st_q.wake_s1;
        st_d.ill_rst = 1'b0;
        st_d.por_rst = 1'b0;
        st_d.dbg_err = 1'b0;
        // hold the pin image until software acknowledges
        if (!st_q.latched) begin
            st_d.pins = pin_ctrl_in;
        end
        if (st_q.latched && st_q.mode != spc_pkg::SPC_STOP2
                && partial_powerdown_acknowledge_in) begin
            st_d.latched = 1'b0;
            st_d.ppd_flag = 1'b0;
        end
        unique case (st_q.mode)
            spc_pkg::SPC_RUN: begin
                if (stop_exec_in && !stop_instruction_enable_in) begin
                    st_d.ill_rst = 1'b1;
                end else if (stop_exec_in) begin
                    // snapshot the configuration that governs stop
                    st_d.dbg_keep = debug_keepalive_enable_in;
                    st_d.lvd_stop = lvd_in_stop;
                    st_d.rtc_keep = rtc_prescale_select_in != spc_pkg::RTC_PS_OFF;
                    st_d.adc_keep = adc_async_clock_enable_in & lvd_in_stop;
                    st_d.cmp_keep = ~comparator_bandgap_select_in | lvd_in_stop;
                    st_d.usb_keep = usb_module_enable_in & usb_transceiver_enable_in;
                    st_d.irc_keep = internal_ref_clock_enable_in
                        & internal_ref_stop_enable_in;
                    st_d.crystal_oscillator_keep = external_ref_clock_enable_in & external_ref_stop_enable_in
                        & (~crystal_high_range_in | lvd_in_stop);
                    if (stop_to_deep) begin
                        st_d.mode = spc_pkg::SPC_STOP2;
                        st_d.latched = 1'b1;
                        st_d.pins = st_q.pins;
                    end else begin
                        st_d.mode = spc_pkg::SPC_STOP3;
                    end
                end
            end
            spc_pkg::SPC_STOP3: begin
                if (dbg_background_cmd_in && st_q.dbg_keep) begin
                    st_d.mode = spc_pkg::SPC_BDM;
                end else if (shallow_wake) begin
                    st_d.mode = spc_pkg::SPC_RUN;
                end
                st_d.dbg_err = dbg_status_mem_cmd_in;
            end
            spc_pkg::SPC_STOP2: begin
                st_d.dbg_err = dbg_status_mem_cmd_in;
                if (deep_wake) begin
                    // wake as from power-on: debug keepalive and lvd stop snapshots cleared, flag raised
                    st_d.mode = spc_pkg::SPC_RUN;
                    st_d.por_rst = 1'b1;
                    st_d.ppd_flag = 1'b1;
                    st_d.dbg_keep = 1'b0;
                    st_d.lvd_stop = 1'b0;
                end
            end
            spc_pkg::SPC_BDM: begin
                if (dbg_go_cmd_in) begin
                    st_d.mode = spc_pkg::SPC_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            st_q <= '0;
            st_q.mode <= spc_pkg::SPC_RUN;
            st_q.rst_s1 <= 1'b1;
            st_q.rst_s2 <= 1'b1;
            st_q.wake_s1 <= 1'b1;
            st_q.wake_s2 <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // outputs
    logic stopped;
    logic deep;
    assign stopped = (st_q.mode == spc_pkg::SPC_STOP3) || (st_q.mode == spc_pkg::SPC_STOP2);
    assign deep = st_q.mode == spc_pkg::SPC_STOP2;

    assign mode_out = st_q.mode;
    assign illegal_opcode_reset_out = st_q.ill_rst;
    assign por_reset_out = st_q.por_rst;
    assign lvd_low_trip_out = st_q.por_rst;
    assign fetch_reset_vector_out = st_q.por_rst;
    assign partial_powerdown_flag_out = st_q.ppd_flag;
    assign pin_ctrl_out = st_q.pins;
    assign periph_clk_en_out = ~stopped;
    assign debug_clk_en_out = ~stopped | st_q.dbg_keep;
    // regulator stays full with debug alive or lvd armed in stop
    assign regulator_full_out = ~stopped | st_q.dbg_keep | st_q.lvd_stop;
    assign core_power_on_out = ~deep;
    assign rtc_run_out = ~stopped | st_q.rtc_keep;
    assign adc_run_out = ~stopped | (~deep & st_q.adc_keep);
    assign comparator_run_out = ~stopped | (~deep & st_q.cmp_keep);
    assign usb_run_out = ~stopped | (~deep & st_q.usb_keep);
    assign internal_ref_run_out = ~stopped | (~deep & st_q.irc_keep);
    assign crystal_run_out = ~stopped | (~deep & st_q.crystal_oscillator_keep);
    assign dbg_status_error_out = st_q.dbg_err;
    assign dbg_full_cmds_out = st_q.mode == spc_pkg::SPC_BDM;

    // ==========================================================
    // checks
    deep_needs_nodbg_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (st_q.mode == spc_pkg::SPC_RUN && stop_exec_in && stop_instruction_enable_in
        && debug_keepalive_enable_in) |=> st_q.mode == spc_pkg::SPC_STOP3)
        else $error("debug enabled stop did not select shallow stop");
    bad_stop_reset_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (st_q.mode == spc_pkg::SPC_RUN && stop_exec_in && !stop_instruction_enable_in)
        |=> illegal_opcode_reset_out && mode_out == spc_pkg::SPC_RUN)
        else $error("disabled stop missed illegal opcode reset");
    dbg_clock_kept_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (stopped && st_q.dbg_keep) |-> debug_clk_en_out && regulator_full_out
        && !periph_clk_en_out)
        else $error("debug clock or regulator wrong in stop");
    stop_status_err_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (stopped && dbg_status_mem_cmd_in) |=> dbg_status_error_out)
        else $error("status command in stop gave no error");
    bg_wake_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (st_q.mode == spc_pkg::SPC_STOP3 && st_q.dbg_keep && dbg_background_cmd_in)
        |=> dbg_full_cmds_out)
        else $error("background command did not enter background mode");
    pins_held_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        deep |=> $stable(pin_ctrl_out))
        else $error("pin image moved in deep stop");
    wake_pin_exit_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (deep && !st_q.wake_s2) |=> por_reset_out && partial_powerdown_flag_out
        && mode_out == spc_pkg::SPC_RUN)
        else $error("wake pin did not leave deep stop as power on");
    flag_until_ack_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (partial_powerdown_flag_out && !partial_powerdown_acknowledge_in)
        |=> partial_powerdown_flag_out)
        else $error("powerdown flag cleared without acknowledge");
    rtc_off_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (st_q.mode == spc_pkg::SPC_RUN && stop_exec_in && stop_instruction_enable_in
        && rtc_prescale_select_in == spc_pkg::RTC_PS_OFF) |=> !rtc_run_out)
        else $error("rtc kept running with zero prescale");
    lvd_forces_shallow_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        (st_q.mode == spc_pkg::SPC_RUN && stop_exec_in && stop_instruction_enable_in
        && lvd_in_stop) |=> mode_out == spc_pkg::SPC_STOP3 && regulator_full_out)
        else $error("lvd in stop did not force shallow stop");

endmodule : spc_stop_ctrl

//--- common/spc_pkg.sv
package spc_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    // two-flop depth on every pin-side input
    localparam int unsigned SYNC_STAGES = 2;
    // width of the rtc prescale select field
    localparam int unsigned RTC_PS_W = 4;
    localparam logic [3:0] RTC_PS_OFF = 4'h0;
    // pin latch width default
    localparam int unsigned PIN_W_DEF = 8;

    // ==========================================================
    // power modes
    typedef enum logic [1:0] {
        SPC_RUN,
        SPC_STOP3,
        SPC_STOP2,
        SPC_BDM
    } spc_mode_t;
endpackage : spc_pkg

//--- verification/spc_far_side_model.sv
`timescale 1ns/10ps
module spc_far_side_model (
    // clock
    input wire logic clk_sys_in,
    // board pins, pulled up when released
    output logic reset_pin_n_out,
    output logic external_wake_pin_n_out,
    // debug host commands
    output logic dbg_background_cmd_out,
    output logic dbg_status_mem_cmd_out,
    output logic dbg_go_cmd_out
);
    initial begin
        reset_pin_n_out = 1'b1;
        external_wake_pin_n_out = 1'b1;
        {dbg_background_cmd_out, dbg_status_mem_cmd_out, dbg_go_cmd_out} = 3'h0;
    end
    // ==========================================================
    // one-cycle low pulse; the pull-up brings the pin straight back high
    task automatic pin_pulse(input bit wake);
        if (wake) begin
            external_wake_pin_n_out = 1'b0;
        end else begin
            reset_pin_n_out = 1'b0;
        end
        @(negedge clk_sys_in);
        external_wake_pin_n_out = 1'b1;
        reset_pin_n_out = 1'b1;
    endtask : pin_pulse
    // ==========================================================
    // 0 background, 1 status memory access, 2 go
    task automatic send_cmd(input int kind);
        dbg_background_cmd_out = (kind == 0);
        dbg_status_mem_cmd_out = (kind == 1);
        dbg_go_cmd_out = (kind == 2);
        @(negedge clk_sys_in);
        {dbg_background_cmd_out, dbg_status_mem_cmd_out, dbg_go_cmd_out} = 3'h0;
    endtask : send_cmd
endmodule : spc_far_side_model

//--- verification/stop_mode_power_controller_tb.sv
`timescale 1ns/10ps
module stop_mode_power_controller_tb;
    logic clk_sys_in = 1'b0, rstn_in = 1'b0, stop_exec_in = 1'b0;
    logic stop_instruction_enable_in = 1'b1, debug_keepalive_enable_in = 1'b0;
    logic low_voltage_detect_enable_in = 1'b0, low_voltage_stop_enable_in = 1'b0;
    logic partial_powerdown_select_in = 1'b0, partial_powerdown_acknowledge_in = 1'b0;
    logic [3:0] rtc_prescale_select_in = 4'h0;
    logic rtc_irq_enable_in = 1'b0, rtc_irq_in = 1'b0, adc_async_clock_enable_in = 1'b0;
    logic comparator_bandgap_select_in = 1'b0, usb_module_enable_in = 1'b0;
    logic usb_transceiver_enable_in = 1'b0, internal_ref_clock_enable_in = 1'b0;
    logic internal_ref_stop_enable_in = 1'b0, external_ref_clock_enable_in = 1'b0;
    logic external_ref_stop_enable_in = 1'b0, crystal_high_range_in = 1'b0;
    logic other_irq_in = 1'b0;
    logic [7:0] pin_ctrl_in = 8'h00;
    logic reset_pin_n_in, external_wake_pin_n_in;
    logic dbg_background_cmd_in, dbg_status_mem_cmd_in, dbg_go_cmd_in;
    logic [1:0] mode_out;
    logic [7:0] pin_ctrl_out;
    logic illegal_opcode_reset_out, por_reset_out, lvd_low_trip_out, fetch_reset_vector_out;
    logic partial_powerdown_flag_out, periph_clk_en_out, debug_clk_en_out;
    logic regulator_full_out, core_power_on_out, rtc_run_out, adc_run_out;
    logic comparator_run_out, usb_run_out, internal_ref_run_out, crystal_run_out;
    logic dbg_status_error_out, dbg_full_cmds_out;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    spc_stop_ctrl i_dut (.*);
    spc_far_side_model i_far (.clk_sys_in(clk_sys_in), .reset_pin_n_out(reset_pin_n_in),
        .external_wake_pin_n_out(external_wake_pin_n_in),
        .dbg_background_cmd_out(dbg_background_cmd_in),
        .dbg_status_mem_cmd_out(dbg_status_mem_cmd_in), .dbg_go_cmd_out(dbg_go_cmd_in));

    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // ==========================================================
    // tasks
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : cyc
    // stop pulse is taken at one rising edge; outputs are settled at the next falling edge
    task automatic stop_now();
        stop_exec_in = 1'b1;
        cyc(1);
        stop_exec_in = 1'b0;
    endtask : stop_now
    task automatic wait_mode(input logic [1:0] m);
        int i;
        for (i = 0; i < 10 && mode_out !== m; i++) @(negedge clk_sys_in);
        chk("mode", {6'h00, mode_out}, {6'h00, m});
    endtask : wait_mode
    task automatic end_sim();
        $display("checks_done %0d num_errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    // ==========================================================
    // watchdog: the whole sequence needs under a hundred cycles
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            end_sim();
        end
    end
    // ==========================================================
    // tests
    initial begin
        cyc(20);
        rstn_in = 1'b1;
        cyc(1);
        chk("run_en", {4'h0, periph_clk_en_out, debug_clk_en_out, core_power_on_out,
            regulator_full_out}, 8'h0F);
        stop_instruction_enable_in = 1'b0;
        stop_now();
        chk("illegal", {mode_out, 5'h00, illegal_opcode_reset_out}, 8'h01);
        stop_instruction_enable_in = 1'b1;
        partial_powerdown_select_in = 1'b1;
        pin_ctrl_in = 8'h5A;
        cyc(2);
        stop_now();
        chk("stop2", {mode_out, core_power_on_out, periph_clk_en_out, debug_clk_en_out,
            regulator_full_out, rtc_run_out, 1'b0}, 8'h80);
        pin_ctrl_in = 8'hA5;
        partial_powerdown_acknowledge_in = 1'b1;
        cyc(1);
        partial_powerdown_acknowledge_in = 1'b0;
        chk("pins", pin_ctrl_out, 8'h5A);
        i_far.pin_pulse(1'b1);
        wait_mode(2'h0);
        chk("por", {4'h0, por_reset_out, lvd_low_trip_out, fetch_reset_vector_out,
            partial_powerdown_flag_out}, 8'h0F);
        cyc(3);
        chk("held", {pin_ctrl_out[7:1], partial_powerdown_flag_out}, 8'h5B);
        partial_powerdown_acknowledge_in = 1'b1;
        cyc(1);
        partial_powerdown_acknowledge_in = 1'b0;
        chk("flag", {7'h00, partial_powerdown_flag_out}, 8'h00);
        cyc(1);
        chk("pins", pin_ctrl_out, 8'hA5);
        debug_keepalive_enable_in = 1'b1;
        stop_now();
        chk("keep", {mode_out, debug_clk_en_out, regulator_full_out, periph_clk_en_out,
            3'h0}, 8'h70);
        i_far.send_cmd(1);
        chk("status", {6'h00, dbg_status_error_out, dbg_full_cmds_out}, 8'h02);
        i_far.send_cmd(0);
        chk("bgnd", {mode_out, 5'h00, dbg_full_cmds_out}, 8'hC1);
        i_far.send_cmd(2);
        wait_mode(2'h0);
        debug_keepalive_enable_in = 1'b0;
        {low_voltage_detect_enable_in, low_voltage_stop_enable_in} = 2'h3;
        {adc_async_clock_enable_in, comparator_bandgap_select_in} = 2'h3;
        {usb_module_enable_in, usb_transceiver_enable_in, crystal_high_range_in} = 3'h7;
        {internal_ref_clock_enable_in, internal_ref_stop_enable_in} = 2'h3;
        {external_ref_clock_enable_in, external_ref_stop_enable_in} = 2'h3;
        rtc_prescale_select_in = 4'h3;
        stop_now();
        chk("lvd", {mode_out, regulator_full_out, rtc_run_out, adc_run_out,
            comparator_run_out, usb_run_out, internal_ref_run_out}, 8'h7F);
        crystal_high_range_in = 1'b1;
        chk("crystal_oscillator", {7'h00, crystal_run_out}, 8'h01);
        other_irq_in = 1'b1;
        wait_mode(2'h0);
        other_irq_in = 1'b0;
        // detect alone, without its stop enable, must not count as lvd in stop
        low_voltage_stop_enable_in = 1'b0;
        adc_async_clock_enable_in = 1'b0;
        usb_transceiver_enable_in = 1'b0;
        external_ref_stop_enable_in = 1'b0;
        {partial_powerdown_select_in, rtc_prescale_select_in} = 5'h00;
        stop_now();
        chk("lite", {mode_out, rtc_run_out, adc_run_out, comparator_run_out, usb_run_out,
            internal_ref_run_out, crystal_run_out}, 8'h42);
        i_far.send_cmd(0);
        chk("nobg", {6'h00, mode_out}, 8'h01);
        rtc_irq_in = 1'b1;
        wait_mode(2'h0);
        rtc_irq_in = 1'b0;
        {partial_powerdown_select_in, rtc_prescale_select_in, rtc_irq_enable_in} = 6'h23;
        stop_now();
        chk("rtc2", {6'h00, mode_out}, 8'h02);
        rtc_irq_in = 1'b1;
        wait_mode(2'h0);
        rtc_irq_in = 1'b0;
        {rtc_prescale_select_in, rtc_irq_enable_in} = 5'h00;
        stop_now();
        i_far.pin_pulse(1'b0);
        wait_mode(2'h0);
        end_sim();
    end
endmodule : stop_mode_power_controller_tb
